// file: hdl/tvi_pkg.sv
// package for the three-level vectored interrupt priority block
// assumes a single system clock and an asynchronous active-high reset
package tvi_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_VEC = 10;
	localparam int NUM_SRC = 35;
	localparam int VEC_IDX_W = 4;
	localparam int VEC_ADDR_W = 20;

	// ----------------------------------------
	// vector addresses
	// ----------------------------------------
	localparam logic [19:0] VEC_BASE = 20'h0_0003;
	localparam logic [19:0] VEC_STEP = 20'h0_0008;

	// ----------------------------------------
	// source counts per vector, index 0 is the lowest address
	// ----------------------------------------
	localparam int SRC_V0 = 1;
	localparam int SRC_V1 = 1;
	localparam int SRC_V2 = 4;
	localparam int SRC_V3 = 3;
	localparam int SRC_V4 = 2;
	localparam int SRC_V5 = 3;
	localparam int SRC_V6 = 5;
	localparam int SRC_V7 = 8;
	localparam int SRC_V8 = 3;
	localparam int SRC_V9 = 5;

	// ----------------------------------------
	// levels; numeric order is the priority order
	// ----------------------------------------
	typedef enum logic [1:0] {
		LVL_NONE = 2'h0,
		LVL_LOW = 2'h1,
		LVL_HIGH = 2'h2,
		LVL_TOP = 2'h3
	} tvi_level_t;

	// source bits of the shared vectors
	typedef struct packed {
		logic smartcard_serial_port_rx_done;
		logic first_duplex_serial_port_rx_done;
		logic usb_suspend;
		logic usb_bus_reset;
		logic first_sync_serial_unit;
	} tvi_v6_src_t;

	typedef struct packed {
		logic smartcard_serial_port_tx_done;
		logic smartcard_serial_port_buf_empty;
		logic first_duplex_serial_port_tx_done;
		logic first_duplex_serial_port_buf_empty;
		logic third_sync_serial_unit;
		logic usb_sof;
		logic usb_endpoint;
		logic second_serial_unit;
	} tvi_v7_src_t;

	// request presented to the core
	typedef struct packed {
		logic valid;
		logic [3:0] index;
		logic [19:0] addr;
		tvi_level_t level;
	} tvi_req_t;

endpackage

// file: hdl/tvi_ctrl.sv
// three-level vectored interrupt priority logic
// assumes sources are on the core clock; external pins are synchronised upstream
// Function
// - thirty-five sources merge onto ten vector addresses, one to eight per vector
// - each vector has level low or, when selected, high (highest for the first two); all comparisons use low, high, highest order
// - while in service, only strictly higher levels may nest
// - among pending vectors the highest level is granted first
// - at equal level the smallest vector address wins
// - vector 00033H gathers serial unit one, usb reset, suspend, two receive-done
// - vector 0003BH gathers serial units two and three, usb events, duplex and smartcard transmit
`timescale 1ns/1ps
module tvi_ctrl
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [tvi_pkg::SRC_V0-1:0] src_v0,
	input wire logic [tvi_pkg::SRC_V1-1:0] src_v1,
	input wire logic [tvi_pkg::SRC_V2-1:0] src_v2,
	input wire logic [tvi_pkg::SRC_V3-1:0] src_v3,
	input wire logic [tvi_pkg::SRC_V4-1:0] src_v4,
	input wire logic [tvi_pkg::SRC_V5-1:0] src_v5,
	input wire tvi_pkg::tvi_v6_src_t src_v6,
	input wire tvi_pkg::tvi_v7_src_t src_v7,
	input wire logic [tvi_pkg::SRC_V8-1:0] src_v8,
	input wire logic [tvi_pkg::SRC_V9-1:0] src_v9,
	input wire logic [tvi_pkg::NUM_VEC-1:0] level_sel_hi,
	input wire logic take,
	input wire logic ret,
	output tvi_pkg::tvi_req_t req,
	output tvi_pkg::tvi_level_t level_in_service
);

	// ----------------------------------------
	// source merge
	// ----------------------------------------
	logic [tvi_pkg::NUM_VEC-1:0] pend;
	tvi_pkg::tvi_level_t vlvl [tvi_pkg::NUM_VEC];

	always_comb
	begin
		pend[0] = |src_v0;
		pend[1] = |src_v1;
		pend[2] = |src_v2;
		pend[3] = |src_v3;
		pend[4] = |src_v4;
		pend[5] = |src_v5;
		pend[6] = |src_v6;
		pend[7] = |src_v7;
		pend[8] = |src_v8;
		pend[9] = |src_v9;
	end

	// first two vectors choose highest, the rest high, else low
	always_comb
	begin
		for (int i = 0; i < tvi_pkg::NUM_VEC; i++)
		begin
			if (!level_sel_hi[i])
				vlvl[i] = tvi_pkg::LVL_LOW;
			else if (i < 2)
				vlvl[i] = tvi_pkg::LVL_TOP;
			else
				vlvl[i] = tvi_pkg::LVL_HIGH;
		end
	end

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	logic win_valid;
	logic [3:0] win_idx;
	tvi_pkg::tvi_level_t win_lvl;

	always_comb
	begin
		win_valid = 1'b0;
		win_idx = 4'h0;
		win_lvl = tvi_pkg::LVL_NONE;
		// ascending scan with strict compare keeps the lowest address on ties
		for (int i = 0; i < tvi_pkg::NUM_VEC; i++)
		begin
			if (pend[i] && vlvl[i] > win_lvl)
			begin
				win_valid = 1'b1;
				win_idx = 4'(i);
				win_lvl = vlvl[i];
			end
		end
	end

	// ----------------------------------------
	// service level stack; one slot per level is enough, nesting is strict
	// ----------------------------------------
	logic [2:0] act_reg;
	logic [2:0] act_next;
	tvi_pkg::tvi_level_t cur;
	logic accept;

	always_comb
	begin
		if (act_reg[2])
			cur = tvi_pkg::LVL_TOP;
		else if (act_reg[1])
			cur = tvi_pkg::LVL_HIGH;
		else if (act_reg[0])
			cur = tvi_pkg::LVL_LOW;
		else
			cur = tvi_pkg::LVL_NONE;
	end

	assign accept = win_valid && (win_lvl > cur);

	always_comb
	begin
		act_next = act_reg;
		if (ret)
		begin
			if (act_reg[2])
				act_next[2] = 1'b0;
			else if (act_reg[1])
				act_next[1] = 1'b0;
			else
				act_next[0] = 1'b0;
		end
		if (take && req.valid)
			act_next[2'(req.level) - 2'h1] = 1'b1;
	end

	// ----------------------------------------
	// request register
	// ----------------------------------------
	tvi_pkg::tvi_req_t req_reg;
	tvi_pkg::tvi_req_t req_next;

	always_comb
	begin
		req_next.valid = accept && !(take && req_reg.valid);
		req_next.index = win_idx;
		req_next.addr = tvi_pkg::VEC_BASE + 20'(win_idx) * tvi_pkg::VEC_STEP;
		req_next.level = accept ? win_lvl : tvi_pkg::LVL_NONE;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			act_reg <= 3'h0;
			req_reg <= '0;
		end
		else
		begin
			act_reg <= act_next;
			req_reg <= req_next;
		end
	end

	assign req = req_reg;
	assign level_in_service = cur;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// watched on the outputs: a request that stands is always above the service level
	property p_nest;
		@(posedge clock) disable iff (rst)
		req.valid |-> req.level > cur;
	endproperty
	a_nest: assert property (p_nest) else $error("request not above service level");

	// only vector five high: it must beat every lower-addressed low vector
	property p_top;
		@(posedge clock) disable iff (rst)
		(pend[5] && level_sel_hi == 10'h020 && cur < tvi_pkg::LVL_HIGH && !(take && req.valid))
			|=> (req.valid && req.index == 4'h5);
	endproperty
	a_top: assert property (p_top) else $error("granted level not highest");

	property p_tie;
		@(posedge clock) disable iff (rst)
		(pend[0] && pend[2] && level_sel_hi == 10'h000 && cur == tvi_pkg::LVL_NONE
			&& !(take && req.valid)) |=> (req.valid && req.index == 4'h0);
	endproperty
	a_tie: assert property (p_tie) else $error("tie not resolved to low address");

	property p_addr;
		@(posedge clock) disable iff (rst)
		req.valid |-> req.addr == 20'h0_0003 + 20'(req.index) * 20'h0_0008;
	endproperty
	a_addr: assert property (p_addr) else $error("vector address mismatch");

	property p_v6;
		@(posedge clock) disable iff (rst)
		(src_v6.usb_bus_reset && cur == tvi_pkg::LVL_NONE && !(take && req.valid))
			|=> req.valid;
	endproperty
	a_v6: assert property (p_v6) else $error("shared vector six not raised");

	property p_v7;
		@(posedge clock) disable iff (rst)
		(src_v7.usb_sof && cur == tvi_pkg::LVL_NONE && !(take && req.valid)) |=> req.valid;
	endproperty
	a_v7: assert property (p_v7) else $error("shared vector seven not raised");

	property p_lvl;
		@(posedge clock) disable iff (rst)
		req.valid |-> req.level != tvi_pkg::LVL_NONE;
	endproperty
	a_lvl: assert property (p_lvl) else $error("request without level");

	sequence s_held;
		pend[9] && cur == tvi_pkg::LVL_NONE && !take && !ret;
	endsequence
	property p_keep;
		@(posedge clock) disable iff (rst)
		s_held ##1 s_held |-> req.valid;
	endproperty
	a_keep: assert property (p_keep) else $error("pending request dropped");

	// a take withdraws the request for a cycle and raises the service level to it
	sequence s_grant;
		take && req.valid;
	endsequence
	sequence s_entered;
		!req.valid && cur == $past(req.level);
	endsequence
	property p_take;
		@(posedge clock) disable iff (rst)
		s_grant |=> s_entered;
	endproperty
	a_take: assert property (p_take) else $error("taken level not entered");

endmodule

// file: sim/tvi_core.sv
// core model that takes the presented vector
// assumes the controller samples take on the next rising edge
`timescale 1ns/1ps
module tvi_core
(
	input wire tvi_pkg::tvi_req_t req,
	input wire logic accept_en,
	output logic take
);
	// a slow core is modelled by holding accept_en low
	assign take = req.valid & accept_en;
endmodule

// file: sim/tb_tvi_ctrl.sv
// bench for tvi_ctrl: sources, level selects, return pulses
// assumes tvi_core answers through take
`timescale 1ns/1ps
module tb_tvi_ctrl;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [34:0] s = '0;
	logic [9:0] sel = '0;
	logic acc = 1'b0;
	logic ret = 1'b0;
	logic take;
	tvi_pkg::tvi_req_t req;
	tvi_pkg::tvi_level_t lis;
	int miscompares = 0;
	int check_count = 0;
	int lo[10] = '{0, 1, 2, 6, 9, 11, 14, 19, 27, 30};
	always #5 clock = ~clock;
	tvi_ctrl dut_u (.clock(clock), .rst(rst), .src_v0(s[0]), .src_v1(s[1]),
		.src_v2(s[5:2]), .src_v3(s[8:6]), .src_v4(s[10:9]), .src_v5(s[13:11]),
		.src_v6(s[18:14]), .src_v7(s[26:19]), .src_v8(s[29:27]),
		.src_v9(s[34:30]), .level_sel_hi(sel), .take(take), .ret(ret),
		.req(req), .level_in_service(lis));
	tvi_core core_u (.req(req), .accept_en(acc), .take(take));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [26:0] got, input logic [26:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	function automatic logic [26:0] rq(input int v, input logic [1:0] l);
		rq = {1'b1, 4'(v), 20'h0_0003 + 20'(v) * 20'h0_0008, l};
	endfunction
	task automatic grant();
		acc = 1'b1;
		cyc(1);
		acc = 1'b0;
	endtask
	task automatic back();
		ret = 1'b1;
		cyc(1);
		ret = 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every source alone, levels alternating so both selects are seen
	task automatic t_map();
		int v;
		logic [1:0] l;
		for (int b = 0; b < 35; b++)
		begin
			v = 0;
			while (v < 9 && lo[v + 1] <= b)
				v++;
			l = b[0] ? ((v < 2) ? 2'h3 : 2'h2) : 2'h1;
			sel = b[0] ? 10'h3ff : 10'h000;
			s = 35'h0_0000_0001 << b;
			cyc(1);
			chk(req, rq(v, l));
			grant();
			chk(27'(lis), 27'(l));
			s = '0;
			back();
			chk(27'(lis), 27'h000_0000);
		end
	endtask
	// all sources at once, then nesting and fall-back
	task automatic t_arb();
		s = '1;
		cyc(1);
		chk(req, rq(0, 2'h1));
		sel = 10'h020;
		cyc(2);
		chk(req, rq(5, 2'h2));
		grant();
		chk(27'(req.valid), 27'h000_0000);
		chk(27'(lis), 27'h000_0002);
		sel = 10'h021;
		cyc(1);
		cyc(1);
		chk(req, rq(0, 2'h3));
		grant();
		chk(27'(lis), 27'h000_0003);
		s[0] = 1'b0;
		back();
		chk(27'(lis), 27'h000_0002);
		chk(27'(req.valid), 27'h000_0000);
		cyc(1);
		chk(27'(req.valid), 27'h000_0000);
		back();
		cyc(1);
		chk(req, rq(5, 2'h2));
		grant();
		chk(27'(lis), 27'h000_0002);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		chk(27'(req), 27'h000_0000);
		chk(27'(lis), 27'h000_0000);
		cyc(1);
		chk(req, rq(5, 2'h2));
		s = '0;
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		cyc(8);
		rst = 1'b0;
		cyc(1);
		t_map();
		t_arb();
		wrap_up();
	end
	// run needs under 200 cycles
	initial
	begin
		#20000;
		miscompares++;
		wrap_up();
	end
endmodule
